// ### sdc_synth_ctrl.v
// synthesizer configuration, reference divider, feedback divider and clock output
`timescale 1ns/100ps
`default_nettype none
`include "sdc_regs.vh"
module sdc_synth_ctrl #(
	parameter REG_READY_CYC = `SDC_REG_READY_CYC
) (
	input wire ref_clk,
	input wire srst,
	input wire ce,
	input wire r0_write,
	input wire [31:0] r0_data,
	input wire r1_write,
	input wire [31:0] r1_data,
	input wire lock_in,
	input wire int_low_ack,
	output reg osc_running,
	output reg [1:0] crystal_bias_setting,
	output reg divided_ref_clock_out,
	output reg phase_detector_ref,
	output reg phase_detector_pulse,
	output reg fb_div_pulse,
	output reg [7:0] fb_int,
	output reg [14:0] fb_frac,
	output reg output_halving_select,
	output reg int_below_min,
	output reg status_mux_pin,
	output reg regulators_on
);
	reg [2:0] mux_sel;
	reg [2:0] ref_div;
	reg [3:0] ckout_div;
	reg osc_enable;
	reg [7:0] int_count;
	reg [15:0] sd_acc;
	reg carry_extra;
	reg ck_level;
	reg [2:0] ref_count;
	reg next_mux_out;
	reg [7:0] eff_int;
	wire supply_ready;
	wire half_tick;
	wire osc_live;
	wire write_ok;

	assign osc_live = osc_enable && ce; // see (RULE1)
	// writes before the regulator settles would be lost by the real part
	assign write_ok = ce && supply_ready; // see (RULE13)

	sdc_regulator #(
		.READY_CYC(REG_READY_CYC)
	) u_reg (
		.ref_clk(ref_clk),
		.srst(srst),
		.ce(ce),
		.ready(supply_ready)
	);

	// configuration storage, cleared whenever chip enable drops
	always @(posedge ref_clk) begin
		if (srst || !ce) begin // see (RULE12)
			mux_sel <= `SDC_RST_MUX; // see (RULE15)
			fb_int <= `SDC_RST_INT;
			fb_frac <= `SDC_RST_FRAC;
			ref_div <= `SDC_RST_RDIV; // see (RULE8)
			ckout_div <= `SDC_RST_CKDIV; // see (RULE5)
			osc_enable <= `SDC_RST_OSCEN; // see (RULE1)
			crystal_bias_setting <= `SDC_RST_BIAS;
			output_halving_select <= 1'b0;
		end else begin
			if (r0_write && write_ok) begin
				mux_sel <= r0_data[`SDC_R0_MUX_MSB:`SDC_R0_MUX_LSB]; // see (RULE14)
				fb_int <= r0_data[`SDC_R0_INT_MSB:`SDC_R0_INT_LSB]; // see (RULE9)
				fb_frac <= r0_data[`SDC_R0_FRAC_MSB:`SDC_R0_FRAC_LSB];
			end
			if (r1_write && write_ok) begin
				ref_div <= r1_data[`SDC_R1_RDIV_MSB:`SDC_R1_RDIV_LSB]; // see (RULE7)
				ckout_div <= r1_data[`SDC_R1_CKDIV_MSB:`SDC_R1_CKDIV_LSB]; // see (RULE3)
				osc_enable <= r1_data[`SDC_R1_OSCEN_BIT];
				crystal_bias_setting <= r1_data[`SDC_R1_BIAS_MSB:`SDC_R1_BIAS_LSB]; // see (RULE2)
				output_halving_select <= r1_data[`SDC_R1_HALF_BIT]; // see (RULE11)
			end
		end
	end

	always @(posedge ref_clk) begin
		if (srst) begin
			osc_running <= 1'b0;
			regulators_on <= 1'b0;
		end else begin
			osc_running <= osc_live; // see (RULE1)
			regulators_on <= ce; // see (RULE12)
		end
	end

	// clock output: toggle every k reference cycles
	sdc_half_div #(
		.W(4)
	) u_ckdiv (
		.ref_clk(ref_clk),
		.srst(srst),
		.en(osc_live),
		.ratio(ckout_div),
		.tick(half_tick)
	);

	always @(posedge ref_clk) begin
		if (srst || !osc_live || ckout_div == 4'h0) begin // see (RULE6)
			ck_level <= 1'b0;
			divided_ref_clock_out <= 1'b0;
		end else begin
			if (half_tick)
				ck_level <= ~ck_level; // see (RULE17)
			// equal halves; inverted from ck_level, its edges on the reference's rising edge
			divided_ref_clock_out <= ~ck_level; // see (RULE4)
		end
	end

	// reference divider; ratio zero treated as one
	always @(posedge ref_clk) begin
		if (srst || !osc_live) begin
			ref_count <= 3'h0;
			phase_detector_pulse <= 1'b0;
			phase_detector_ref <= 1'b0;
		end else if (ref_count + 3'h1 >= ref_div) begin // see (RULE7)
			ref_count <= 3'h0;
			phase_detector_pulse <= 1'b1;
			phase_detector_ref <= ~phase_detector_ref;
		end else begin
			ref_count <= ref_count + 3'h1;
			phase_detector_pulse <= 1'b0;
		end
	end

	// integer below the minimum is clamped and flagged
	always @* begin
		eff_int = fb_int;
		if (fb_int < `SDC_MIN_INT)
			eff_int = `SDC_MIN_INT; // see (RULE10)
	end

	// feedback divider: first-order sigma-delta adds one count on carry
	always @(posedge ref_clk) begin
		if (srst || !osc_live) begin
			int_count <= 8'h0;
			sd_acc <= 16'h0;
			carry_extra <= 1'b0;
			fb_div_pulse <= 1'b0;
			int_below_min <= 1'b0;
		end else begin
			int_below_min <= fb_int < `SDC_MIN_INT; // see (RULE10)
			if (int_count >= eff_int - {7'h0, ~carry_extra}) begin
				int_count <= 8'h0;
				fb_div_pulse <= 1'b1;
				sd_acc <= {1'b0, sd_acc[14:0]} + {1'b0, fb_frac}; // see (RULE9)
				carry_extra <= sd_acc[15];
			end else begin
				int_count <= int_count + 8'h1;
				fb_div_pulse <= 1'b0;
			end
		end
	end

	always @* begin
		case (mux_sel)
			`SDC_MUX_REG_READY: next_mux_out = supply_ready; // see (RULE15)
			`SDC_MUX_LOCK: next_mux_out = lock_in;
			`SDC_MUX_PD_REF: next_mux_out = phase_detector_ref;
			`SDC_MUX_FB_DIV: next_mux_out = fb_div_pulse;
			`SDC_MUX_OSC_ON: next_mux_out = osc_running;
			`SDC_MUX_LOW: next_mux_out = 1'b0;
			`SDC_MUX_HIGH: next_mux_out = 1'b1;
			`SDC_MUX_INT_LOW: next_mux_out = int_below_min;
			default: next_mux_out = 1'b0;
		endcase
	end

	always @(posedge ref_clk) begin
		if (srst || !ce)
			status_mux_pin <= 1'b0;
		else
			status_mux_pin <= next_mux_out; // see (RULE14) (RULE16)
	end
endmodule // sdc_synth_ctrl
`default_nettype wire

// ### sdc_regs.vh
// constants for the synthesizer divider and clock output control block
// Notes on behaviour
// (RULE1) oscillator runs while its enable bit is high; set at power-up, stops when ce low
// (RULE2) two-bit crystal bias field selects bias 20 to 35 uA; higher starts faster
// (RULE3) clock output divider gives even ratios 2 to 30 from a four-bit field
// (RULE4) divided clock output has equal high and low times, inverted to the reference
// (RULE5) clock output divide ratio defaults to eight after power-up
// (RULE6) divide field of zero disables the divided clock output
// (RULE7) three-bit reference divider divides by 1 to 7, feeding the phase detector
// (RULE8) reference divider ratio defaults to one at power-up
// (RULE9) feedback divider: 8-bit integer, 15-bit fraction via sigma-delta over 2^15
// (RULE10) integer feedback value must not be programmed below 23
// (RULE11) output halving multiplies synthesized frequency by one half
// (RULE12) chip-enable low powers down regulators and clears all configuration
// (RULE13) host keeps chip-enable high and waits for regulator before writing
// (RULE14) three-bit select field in first register picks the status mux source
// (RULE15) status mux defaults to supply-ready, rising about 50 us after enable
// (RULE16) host programs only after seeing supply-ready high on the status mux pin
// (RULE17) nonzero divide field k gives ratio 2k, each half-period k reference cycles
`ifndef SDC_REGS_VH
`define SDC_REGS_VH
`define SDC_R0_FRAC_LSB 4
`define SDC_R0_FRAC_MSB 18
`define SDC_R0_INT_LSB 19
`define SDC_R0_INT_MSB 26
`define SDC_R0_MUX_LSB 29
`define SDC_R0_MUX_MSB 31
`define SDC_R1_RDIV_LSB 4
`define SDC_R1_RDIV_MSB 6
`define SDC_R1_CKDIV_LSB 7
`define SDC_R1_CKDIV_MSB 10
`define SDC_R1_OSCEN_BIT 12
`define SDC_R1_BIAS_LSB 13
`define SDC_R1_BIAS_MSB 14
`define SDC_R1_HALF_BIT 18
`define SDC_RST_MUX 3'h0
`define SDC_RST_RDIV 3'h1
`define SDC_RST_CKDIV 4'h4
`define SDC_RST_OSCEN 1'b1
`define SDC_RST_BIAS 2'h0
`define SDC_RST_INT 8'h17
`define SDC_RST_FRAC 15'h0000
`define SDC_MIN_INT 8'h17
`define SDC_MUX_REG_READY 3'h0
`define SDC_MUX_LOCK 3'h1
`define SDC_MUX_PD_REF 3'h2
`define SDC_MUX_FB_DIV 3'h3
`define SDC_MUX_OSC_ON 3'h4
`define SDC_MUX_LOW 3'h5
`define SDC_MUX_HIGH 3'h6
`define SDC_MUX_INT_LOW 3'h7
`define SDC_CLK_MHZ 50
`define SDC_REG_READY_US 50
`define SDC_REG_READY_CYC (`SDC_REG_READY_US * `SDC_CLK_MHZ)
`endif

// ### sdc_half_div.v
// programmable counter giving a one-cycle pulse every ratio enabled cycles
`timescale 1ns/100ps
`default_nettype none
module sdc_half_div #(
	parameter W = 4
) (
	input wire ref_clk,
	input wire srst,
	input wire en,
	input wire [W-1:0] ratio,
	output reg tick
);
	reg [W-1:0] count;
	// ratio zero clears the counter; caller gates the output
	always @(posedge ref_clk) begin
		if (srst || !en || ratio == {W{1'b0}}) begin
			count <= {W{1'b0}};
			tick <= 1'b0;
		end else if (count >= ratio - {{(W-1){1'b0}}, 1'b1}) begin
			count <= {W{1'b0}};
			tick <= 1'b1;
		end else begin
			count <= count + {{(W-1){1'b0}}, 1'b1};
			tick <= 1'b0;
		end
	end
endmodule // sdc_half_div
`default_nettype wire

// ### sdc_regulator.v
// supply-ready timer started by chip enable
`timescale 1ns/100ps
`default_nettype none
module sdc_regulator #(
	parameter READY_CYC = 2500
) (
	input wire ref_clk,
	input wire srst,
	input wire ce,
	output reg ready
);
	reg [31:0] count;
	always @(posedge ref_clk) begin
		if (srst || !ce) begin
			count <= 32'h0;
			ready <= 1'b0;
		end else if (count >= READY_CYC - 1) begin
			ready <= 1'b1; // see (RULE15)
		end else begin
			count <= count + 32'h1;
		end
	end
endmodule // sdc_regulator
`default_nettype wire

// ### sdc_chk_monitor.sv
// checker for the synthesizer control outputs
`timescale 1ns/100ps
`default_nettype none
module sdc_chk_monitor #(parameter REG_READY_CYC = 8) (
	input wire ref_clk,
	input wire srst,
	input wire ce,
	input wire r0_write,
	input wire [31:0] r0_data,
	input wire r1_write,
	input wire [31:0] r1_data,
	input wire osc_running,
	input wire [1:0] crystal_bias_setting,
	input wire divided_ref_clock_out,
	input wire [7:0] fb_int,
	input wire [14:0] fb_frac,
	input wire output_halving_select,
	input wire int_below_min,
	input wire status_mux_pin,
	input wire phase_detector_ref,
	input wire phase_detector_pulse,
	input wire fb_div_pulse,
	input wire regulators_on
);
	reg [31:0] d0, d1;
	reg [15:0] cnt, age;
	reg [4:0] run;
	reg [3:0] k;
	reg last;
	reg [2:0] m;
	// margin past supply ready, so a counted write is surely taken
	wire ok = ce && cnt > REG_READY_CYC + 2;
	wire clr = srst || !ce;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	always @(posedge ref_clk) begin
		d0 <= r0_data;
		d1 <= r1_data;
		last <= divided_ref_clock_out;
		run <= (last != divided_ref_clock_out) ? 5'h1 : run + 5'h1;
		cnt <= clr ? 16'h0 : cnt + {15'h0, cnt != 16'hffff};
		age <= (clr || (r1_write && ok)) ? 16'h0 : age + {15'h0, age != 16'hffff};
		k <= clr ? 4'h4 : (r1_write && ok) ? r1_data[10:7] : k;
		m <= clr ? 3'h0 : (r0_write && ok) ? r0_data[31:29] : m;
	end
	chk_osc_stop: assert property (!ce |=> !osc_running) else $error("osc on");
	chk_ce_clear: assert property (!ce ##1 !ce |=> !status_mux_pin) else $error("mux on");
	chk_bias_load: assert property (r1_write && ok |=>
		crystal_bias_setting == d1[14:13] && output_halving_select == d1[18]) else $error("r1");
	chk_fb_load: assert property (r0_write && ok |=>
		fb_int == d0[26:19] && fb_frac == d0[18:4]) else $error("r0");
	// flag is held low while the oscillator is stopped
	chk_int_floor: assert property ($stable(fb_int) |->
		int_below_min == (osc_running && fb_int < 8'h17)) else $error("floor");
	chk_clk_quiet: assert property (k == 4'h0 && age > 16'h3 |->
		!divided_ref_clock_out) else $error("clk on");
	chk_half_period: assert property (last != divided_ref_clock_out && age > 16'h28
		|-> run == {1'b0, k}) else $error("half period");
	chk_mux_early: assert property (cnt > 16'h2 && cnt < REG_READY_CYC - 1 |->
		!status_mux_pin) else $error("early");
	chk_pd_toggle: assert property (phase_detector_pulse |->
		phase_detector_ref != $past(phase_detector_ref)) else $error("pd ref");
	chk_reg_power: assert property (!$past(srst) |->
		regulators_on == $past(ce)) else $error("regulators");
	chk_mux_pdref: assert property ($stable(m) && m == 3'h2 |->
		status_mux_pin == $past(phase_detector_ref)) else $error("mux pd ref");
	chk_mux_fbdiv: assert property ($stable(m) && m == 3'h3 |->
		status_mux_pin == $past(fb_div_pulse)) else $error("mux fb div");
endmodule // sdc_chk_monitor
bind sdc_synth_ctrl sdc_chk_monitor #(.REG_READY_CYC(REG_READY_CYC)) sdc_chk_monitor_inst (
	.ref_clk, .srst, .ce, .r0_write, .r0_data, .r1_write, .r1_data, .osc_running,
	.crystal_bias_setting, .divided_ref_clock_out, .fb_int, .fb_frac,
	.output_halving_select, .int_below_min, .status_mux_pin, .phase_detector_ref,
	.phase_detector_pulse, .fb_div_pulse, .regulators_on);
`default_nettype wire

// ### sdc_host_model.sv
// host model: powers the part, waits for supply ready
`timescale 1ns/100ps
`default_nettype none
module sdc_host_model (
	input wire ref_clk,
	input wire srst,
	input wire drop,
	input wire status_mux_pin,
	output reg ce,
	output reg host_ok
);
	initial ce = 1'b0;
	initial host_ok = 1'b0;
	always @(posedge ref_clk) begin
		ce <= !drop;
		host_ok <= !srst && ce && !drop && (host_ok || status_mux_pin);
	end
endmodule // sdc_host_model
`default_nettype wire

// ### sdc_synth_ctrl_tb_top.sv
// self-checking bench for the synthesizer control block
`timescale 1ns/100ps
`default_nettype none
`define CMP(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; $display("wrong value %0t %h %h", $time, g, e); end end
module sdc_synth_ctrl_tb_top;
	reg ref_clk = 0, srst = 1, r0_write = 0, r1_write = 0, lock_in = 0, drop = 0, eh, eo, rd = 0;
	reg [31:0] r0_data = 0, r1_data = 0;
	wire ce, host_ok, osc_running, divided_ref_clock_out, phase_detector_pulse;
	wire output_halving_select, int_below_min, status_mux_pin, fb_div_pulse;
	wire [1:0] crystal_bias_setting;
	wire [7:0] fb_int;
	wire [14:0] fb_frac;
	integer bad_count = 0, samples_checked = 0, i, n;
	reg [32:0] q[$];
	reg [32:0] nt;
	reg [8:0] pd = 0, pdw;
	reg [8:0] pf = 0;
	reg [7:0] ei;
	reg [14:0] ef;
	reg [2:0] em;
	reg [1:0] eb;
	wire [31:0] obs = {3'h0, status_mux_pin, osc_running, output_halving_select,
		crystal_bias_setting, fb_int, fb_frac, int_below_min};
	always #10 ref_clk = ~ref_clk;
	sdc_host_model sdc_host_model_inst (.ref_clk, .srst, .drop, .status_mux_pin, .ce, .host_ok);
	sdc_synth_ctrl #(.REG_READY_CYC(8)) sdc_synth_ctrl_inst (.ref_clk, .srst, .ce, .r0_write,
		.r0_data, .r1_write, .r1_data, .lock_in, .int_low_ack(1'b0), .osc_running,
		.crystal_bias_setting, .divided_ref_clock_out, .phase_detector_ref(),
		.phase_detector_pulse, .fb_div_pulse, .fb_int, .fb_frac, .output_halving_select,
		.int_below_min, .status_mux_pin, .regulators_on());
	function logic [31:0] ex();
		logic p;
		case (em)
			3'h0: p = rd;
			3'h1: p = lock_in;
			3'h4: p = eo;
			3'h6: p = 1'b1;
			3'h7: p = eo && ei < 8'h17;
			default: p = 1'b0;
		endcase
		return {3'h0, p, eo, eh, eb, ei, ef, (eo && ei < 8'h17)};
	endfunction
	task tick(input integer c);
		repeat (c) @(posedge ref_clk);
		#1;
	endtask
	task dflt;
		ei = 8'h17;
		ef = 0;
		eb = 0;
		eh = 0;
		em = 0;
	endtask
	task wr(input b, input [31:0] d);
		r0_data = d;
		r1_data = d;
		r0_write = !b;
		r1_write = b;
		tick(1);
		r0_write = 0;
		r1_write = 0;
		tick(3);
		q.push_back({1'b0, ex()});
	endtask
	task rdy;
		n = 0;
		while (!host_ok && n < 400) begin
			tick(1);
			n++;
		end
		if (!host_ok) bad_count++;
		tick(3);
		rd = 1;
		eo = 1;
		q.push_back({1'b0, ex()});
	endtask
	// a whole number of periods for every ratio 1 to 7
	task pdm(input [7:0] r);
		tick(10);
		n = pd;
		tick(420);
		pdw = pd - n[8:0];
		q.push_back({24'h800000, 9'h1a4 / r});
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge ref_clk) pd <= pd + {8'h0, phase_detector_pulse};
	always @(posedge ref_clk) pf <= pf + {8'h0, fb_div_pulse};
	always @(negedge ref_clk) if (q.size() > 0) begin
		nt = q.pop_front();
		if (nt[32]) `CMP(pdw, nt[8:0])
		else `CMP(obs, nt[31:0])
	end
	initial begin
		#200000;
		bad_count++;
		close_out;
	end
	initial begin
		i = $urandom(39);
		dflt;
		eo = 1;
		tick(20);
		srst = 0;
		rdy;
		$display("test defaults done");
		for (i = 0; i < 8; i++) if (i != 2 && i != 3) begin
			em = i;
			ei = (i == 7) ? 8'h16 : 8'(8'h17 + $urandom % 200);
			ef = 15'($urandom);
			lock_in = 1'($urandom);
			wr(0, {em, 2'h0, ei, ef, 4'h0});
		end
		$display("test mux done");
		for (i = 1; i < 8; i++) begin
			eb = 2'($urandom);
			eh = 1'($urandom);
			wr(1, {13'h0, eh, 3'h0, eb, 2'h2, 4'($urandom), i[2:0], 4'h1});
			pdm(i[7:0]);
		end
		eo = 0;
		eb = 0;
		eh = 0;
		wr(1, 32'h0);
		$display("test dividers done");
		dflt;
		rd = 0;
		drop = 1;
		tick(3);
		wr(0, 32'hfffffff0);
		drop = 0;
		rdy;
		pdm(8'h1);
		// zero fraction: one feedback pulse every 23 cycles
		n = pf;
		tick(460);
		pdw = pf - n[8:0];
		q.push_back({24'h800000, 9'h014});
		// dynamic mux sources, watched by the checker
		for (i = 2; i < 4; i++) begin
			r0_data = {i[2:0], 2'h0, 8'h17, 15'h0, 4'h0};
			r0_write = 1;
			tick(1);
			r0_write = 0;
			tick(60);
		end
		em = 6;
		wr(0, {3'h6, 2'h0, 8'h17, 15'h0, 4'h0});
		srst = 1;
		tick(2);
		dflt;
		rd = 0;
		eo = 0;
		q.push_back({1'b0, ex()});
		srst = 0;
		rdy;
		tick(2);
		$display("test power cycle done");
		close_out;
	end
endmodule // sdc_synth_ctrl_tb_top
`default_nettype wire
